// ### machine_cycle_and_external_data_move_stretch_tb_top.sv
`timescale 1ns/1ps
module machine_cycle_and_external_data_move_stretch_tb_top;
  import mcs_timing_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, extResetReq = 1'b0, ctrlWrite = 1'b0;
  logic instrJump = 1'b0, instrExtra = 1'b0, instrExtMove = 1'b0, instrExtWrite = 1'b0;
  logic [1:0] instrBytes = 2'h0;
  logic [2:0] rdDelay = 3'h0;
  logic [7:0] ctrlWriteData = 8'h00, instrExtWrData = 8'h00, rdSeen = 8'h00;
  logic [15:0] instrExtAddr = 16'h0000, jumpTarget = 16'h0A5C, pcRef = 16'h0000;
  logic fetchStrobe, extAddrValid, extRdN, extWrN, extDataOe, rdDataValid, instrDone, cpuHold, cpuReset;
  logic [15:0] pc, extAddr;
  logic [7:0] extWrData, extRdData, rdData;
  logic [2:0] stretchSel;
  mcs_state_e cpuState;
  int err_count = 0, tests_run = 0, fetchCnt = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (fetchStrobe === 1'b1) fetchCnt++;
  mcs_core DUT (.clk, .rstn, .extResetReq, .ctrlWrite, .ctrlWriteData, .instrBytes, .instrJump,
    .instrExtra, .instrExtMove, .instrExtWrite, .instrExtAddr, .instrExtWrData, .jumpTarget,
    .fetchStrobe, .pc, .extAddr, .extAddrValid, .extRdN, .extWrN, .extWrData, .extDataOe,
    .extRdData, .rdData, .rdDataValid, .cpuState, .stretchSel, .instrDone, .cpuHold, .cpuReset);
  mcs_ext_mem u_mem (.clk, .extAddr, .extRdN, .extWrN, .extWrData, .extDataOe, .rdDelay, .extRdData);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic set_stretch(input logic [2:0] s);
    ctrlWriteData = {5'h1F, s};
    ctrlWrite = 1'b1;
    tick(1);
    ctrlWrite = 1'b0;
    tick(1);
    check(stretchSel, s);
  endtask : set_stretch
  // f holds jump, extra, move, write; c is the machine cycle count expected
  task automatic issue(input logic [1:0] b, input logic [3:0] f, input logic [7:0] a, input int c);
    int n;
    int h;
    n = 0;
    h = 0;
    while (cpuState !== STATE_FOURTH && n < 8) begin
      tick(1);
      n++;
    end
    {instrJump, instrExtra, instrExtMove, instrExtWrite} = f;
    instrBytes = b;
    instrExtAddr = {8'h00, a};
    instrExtWrData = 8'hA0 ^ a;
    tick(1);
    {instrJump, instrExtra, instrExtMove, instrExtWrite} = 4'h0;
    n = 1;
    while (instrDone !== 1'b1 && n < 60) begin
      if (rdDataValid === 1'b1) rdSeen = rdData;
      if (cpuHold === 1'b1) h++;
      tick(1);
      n++;
    end
    if (rdDataValid === 1'b1) rdSeen = rdData;
    check(n, 4 * (c - 1) + 1);
    check(fetchCnt, b);
    check(h, f[1] ? 4 * (c - 1) - 1 : 0);
    check(pc, f[3] ? jumpTarget : pcRef + 16'(b));
    pcRef = pc;
    fetchCnt = 0;
  endtask : issue
  task automatic t_reset_state();
    check({pc, stretchSel, extRdN, extWrN}, {PC_RESET, 3'h1, 2'b11});
    issue(2'h1, 4'b0011, 8'hF0, 3);
  endtask : t_reset_state
  task automatic t_classes();
    set_stretch(3'h7);
    issue(2'h1, 4'b0000, 8'h00, 1);
    issue(2'h2, 4'b0000, 8'h00, 2);
    issue(2'h1, 4'b0100, 8'h00, 2);
    issue(2'h3, 4'b0000, 8'h00, 3);
    issue(2'h3, 4'b1000, 8'h00, 4);
    issue(2'h3, 4'b1100, 8'h00, 5);
  endtask : t_classes
  task automatic t_moves();
    for (int s = 0; s < 8; s++) begin
      set_stretch(3'(s));
      rdDelay = (s == 0) ? 3'h0 : 3'h2;
      issue(2'h1, 4'b0011, 8'(s), s + 2);
      rdSeen = 8'h00;
      issue(2'h1, 4'b0010, 8'(s), s + 2);
      check(rdSeen, 8'hA0 ^ 8'(s));
    end
  endtask : t_moves
  task automatic t_ext_reset();
    set_stretch(3'h5);
    extResetReq = 1'b1;
    tick(4);
    extResetReq = 1'b0;
    tick(8);
    check(cpuReset, 1'b0);
    extResetReq = 1'b1;
    tick(12);
    check({cpuReset, stretchSel, pc}, {1'b1, 3'h1, PC_RESET});
    extResetReq = 1'b0;
    tick(16);
    check(cpuReset, 1'b0);
  endtask : t_ext_reset
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset_state();
    t_classes();
    t_moves();
    t_ext_reset();
    wrap_up();
  end
endmodule : machine_cycle_and_external_data_move_stretch_tb_top

// ### mcs_core.sv
`timescale 1ns/1ps
module mcs_core
  import mcs_timing_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     extResetReq,
  // clock control write
  input  wire logic                     ctrlWrite,
  input  wire logic [7:0]               ctrlWriteData,
  // decode of the fetched opcode, valid in state four of the fetch cycle
  input  wire logic [1:0]               instrBytes,
  input  wire logic                     instrJump,
  input  wire logic                     instrExtra,
  input  wire logic                     instrExtMove,
  input  wire logic                     instrExtWrite,
  input  wire logic [15:0]              instrExtAddr,
  input  wire logic [7:0]               instrExtWrData,
  input  wire logic [15:0]              jumpTarget,
  // program fetch
  output logic                          fetchStrobe,
  output logic [15:0]                   pc,
  // external data bus
  output logic [15:0]                   extAddr,
  output logic                          extAddrValid,
  output logic                          extRdN,
  output logic                          extWrN,
  output logic [7:0]                    extWrData,
  output logic                          extDataOe,
  input  wire logic [7:0]               extRdData,
  output logic [7:0]                    rdData,
  output logic                          rdDataValid,
  // status
  output mcs_timing_pkg::mcs_state_e    cpuState,
  output logic [2:0]                    stretchSel,
  output logic                          instrDone,
  output logic                          cpuHold,
  output logic                          cpuReset
);
  logic [1:0] phase;
  logic       phaseWrap;
  logic [7:0] clockControl;
  logic [2:0] cycIdx;
  logic [2:0] totCyc;
  logic [1:0] bytesLeft;
  logic       jumpPend;
  logic       inMove;
  logic       moveWrite;
  logic [4:0] accessClk;
  logic [4:0] accessLast;
  logic [4:0] strobeWidth;
  logic [2:0] moveStretch;
  logic       rstSeen;
  logic [1:0] rstHold;
  logic       atFourth;
  logic       strobeWin;
  logic [2:0] next_totCyc;
  logic [2:0] next_sum;

  mcs_mod_counter #(.WIDTH(2), .MOD(STATES_PER_CYCLE)) u_phase (
    .clk      (clk),
    .rstn     (rstn),
    .count    (phase),
    .wrapNext (phaseWrap)
  );

  assign atFourth = phaseWrap;

  // state output tracks the counter; reset value matches the counter's
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuState <= STATE_FIRST;
    end else begin
      cpuState <= mcs_state_e'(phase + 2'h1);
    end
  end

  // reset pin seen only once per machine cycle; one glitchy sample is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSeen  <= 1'b0;
      rstHold  <= 2'h0;
      cpuReset <= 1'b0;
    end else if (atFourth) begin
      rstSeen <= extResetReq;
      if (extResetReq && (rstSeen || cpuReset)) begin
        cpuReset <= 1'b1;
        rstHold  <= RESET_HOLD_CYCLES;
      end else if (cpuReset) begin
        if (rstHold <= 2'h1) begin
          cpuReset <= 1'b0;
        end
        rstHold <= (rstHold == 2'h0) ? 2'h0 : rstHold - 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clockControl <= CLOCK_CONTROL_RESET;
    end else if (cpuReset) begin
      clockControl <= CLOCK_CONTROL_RESET;
    end else if (ctrlWrite) begin
      clockControl <= ctrlWriteData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stretchSel <= CLOCK_CONTROL_RESET[STRETCH_MSB:STRETCH_LSB];
    end else begin
      stretchSel <= clockControl[STRETCH_MSB:STRETCH_LSB];
    end
  end

  // cycle count: bytes, plus one for jumps, plus one for codes flagged extra, of any length
  always_comb begin
    next_sum    = {1'b0, instrBytes} + {2'h0, instrJump} + {2'h0, instrExtra};
    next_totCyc = (next_sum == 3'h0) ? 3'h1 : next_sum;
  end

  // access length is (stretch+1) machine cycles; strobe 2 clocks or 4 per step
  assign accessLast  = {moveStretch, 2'b11};
  assign strobeWidth = (moveStretch == 3'h0) ? STROBE_WIDTH_MIN : {moveStretch, 2'b00};
  assign strobeWin   = inMove && (accessClk >= STROBE_LEAD) && (accessClk < STROBE_LEAD + strobeWidth);

  // instruction sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cycIdx      <= 3'h0;
      totCyc      <= 3'h1;
      bytesLeft   <= 2'h0;
      jumpPend    <= 1'b0;
      inMove      <= 1'b0;
      moveWrite   <= 1'b0;
      moveStretch <= 3'h0;
      accessClk   <= 5'h00;
      instrDone   <= 1'b0;
    end else if (cpuReset) begin
      cycIdx    <= 3'h0;
      bytesLeft <= 2'h0;
      jumpPend  <= 1'b0;
      inMove    <= 1'b0;
      accessClk <= 5'h00;
      instrDone <= 1'b0;
    end else if (inMove) begin
      // processor state frozen: only the access counter runs
      instrDone <= 1'b0;
      if (accessClk == accessLast) begin
        inMove    <= 1'b0;
        accessClk <= 5'h00;
        instrDone <= 1'b1;
      end else begin
        accessClk <= accessClk + 5'h01;
      end
    end else if (atFourth) begin
      if (cycIdx == 3'h0) begin
        if (instrExtMove) begin
          inMove      <= 1'b1;
          moveWrite   <= instrExtWrite;
          moveStretch <= clockControl[STRETCH_MSB:STRETCH_LSB];
          instrDone   <= 1'b0;
        end else if (next_totCyc == 3'h1) begin
          instrDone <= 1'b1;
        end else begin
          cycIdx    <= 3'h1;
          totCyc    <= next_totCyc;
          bytesLeft <= (instrBytes == 2'h0) ? 2'h0 : instrBytes - 2'h1;
          jumpPend  <= instrJump;
          instrDone <= 1'b0;
        end
      end else if (cycIdx == totCyc - 3'h1) begin
        cycIdx    <= 3'h0;
        jumpPend  <= 1'b0;
        instrDone <= 1'b1;
      end else begin
        cycIdx    <= cycIdx + 3'h1;
        instrDone <= 1'b0;
        if (bytesLeft != 2'h0) begin
          bytesLeft <= bytesLeft - 2'h1;
        end
      end
    end else begin
      instrDone <= 1'b0;
    end
  end

  // one fetch at the second state of a cycle that still has a byte to take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetchStrobe <= 1'b0;
      pc          <= PC_RESET;
    end else if (cpuReset) begin
      fetchStrobe <= 1'b0;
      pc          <= PC_RESET;
    end else begin
      fetchStrobe <= 1'b0;
      if (!inMove && (phase == STATE_FIRST) && (cycIdx == 3'h0 || bytesLeft != 2'h0)) begin
        fetchStrobe <= 1'b1;
        pc          <= pc + 16'h0001;
      end else if (!inMove && atFourth && cycIdx != 3'h0 && cycIdx == totCyc - 3'h1 && jumpPend) begin
        pc <= jumpTarget;
      end
    end
  end

  // hold flag shows the frozen processor during the stretched access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuHold <= 1'b0;
    end else begin
      cpuHold <= inMove && !cpuReset && (accessClk != accessLast);
    end
  end

  // address and write data are held across the whole access so the strobe,
  // which ends at least one clock early, always drops while the address is stable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extAddr      <= 16'h0000;
      extAddrValid <= 1'b0;
      extWrData    <= 8'h00;
      extDataOe    <= 1'b0;
    end else if (!cpuReset && !inMove && atFourth && cycIdx == 3'h0 && instrExtMove) begin
      extAddr      <= instrExtAddr;
      extAddrValid <= 1'b1;
      extWrData    <= instrExtWrData;
      extDataOe    <= instrExtWrite;
    end else if (cpuReset || (inMove && accessClk == accessLast)) begin
      extAddrValid <= 1'b0;
      extDataOe    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extRdN <= 1'b1;
      extWrN <= 1'b1;
    end else begin
      extRdN <= !(strobeWin && !moveWrite && !cpuReset);
      extWrN <= !(strobeWin && moveWrite && !cpuReset);
    end
  end

  // read data taken on the falling edge inside the last strobe clock,
  // half a state later than a rising-edge capture would allow
  always_ff @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 8'h00;
    end else if (inMove && !moveWrite && accessClk == strobeWidth) begin
      rdData <= extRdData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdDataValid <= 1'b0;
    end else begin
      rdDataValid <= inMove && !moveWrite && !cpuReset && accessClk == accessLast;
    end
  end
endmodule : mcs_core

// ### mcs_core_checker.sv
`timescale 1ns/1ps
module mcs_core_checker
  import mcs_timing_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched outputs
  input wire logic fetchStrobe,
  input wire logic [15:0] pc,
  input wire logic extAddrValid,
  input wire logic extRdN,
  input wire logic extWrN,
  input wire mcs_timing_pkg::mcs_state_e cpuState,
  input wire logic [2:0] stretchSel,
  input wire logic cpuHold,
  input wire logic cpuReset
);
  logic [5:0] lowCnt;
  logic [5:0] validCnt;
  logic [2:0] moveSel;
  logic [5:0] expWidth;
  assign expWidth = (moveSel == 3'h0) ? 6'h02 : {1'b0, moveSel, 2'b00};
  // stretch is frozen at access start; later writes must not move the width
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) moveSel <= 3'h1;
    else if (!extAddrValid) moveSel <= stretchSel;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lowCnt <= 6'h00;
    else lowCnt <= (extRdN && extWrN) ? 6'h00 : lowCnt + 6'h01;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) validCnt <= 6'h00;
    else validCnt <= extAddrValid ? validCnt + 6'h01 : 6'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_state_seq: assert property (
    $past(rstn) && !cpuReset && !$past(cpuReset) |-> cpuState == mcs_state_e'($past(cpuState) + 2'h1))
    else $error("state order broken");
  a_fetch_state: assert property (fetchStrobe |-> cpuState == STATE_SECOND)
    else $error("fetch outside second state");
  a_strobe_excl: assert property (!(!extRdN && !extWrN))
    else $error("both strobes low");
  a_strobe_addr: assert property (!(extRdN && extWrN) |-> extAddrValid)
    else $error("strobe without address");
  a_release_first: assert property ($fell(extAddrValid) |-> $past(extRdN) && $past(extWrN))
    else $error("address dropped under strobe");
  a_strobe_width: assert property ($rose(extRdN && extWrN) |-> lowCnt == expWidth)
    else $error("strobe width wrong");
  a_move_len: assert property (
    $fell(extAddrValid) |-> validCnt == {1'b0, moveSel, 2'b00} + 6'h04)
    else $error("access length wrong");
  a_reset_vals: assert property (
    cpuReset && $past(cpuReset) && $past(cpuReset, 2) |-> pc == PC_RESET && stretchSel == 3'h1)
    else $error("reset values wrong");
  a_hold_access: assert property (cpuHold |-> extAddrValid && !fetchStrobe)
    else $error("hold outside access or fetch during hold");
endmodule : mcs_core_checker

bind mcs_core mcs_core_checker u_chk (.clk, .rstn, .fetchStrobe, .pc, .extAddrValid,
  .extRdN, .extWrN, .cpuState, .stretchSel, .cpuHold, .cpuReset);

// ### mcs_ext_mem.sv
`timescale 1ns/1ps
module mcs_ext_mem (
  // data bus from the core
  input  wire logic clk,
  input  wire logic [15:0] extAddr,
  input  wire logic extRdN,
  input  wire logic extWrN,
  input  wire logic [7:0] extWrData,
  input  wire logic extDataOe,
  // clocks of low strobe before read data is good
  input  wire logic [2:0] rdDelay,
  output logic [7:0] extRdData
);
  logic [7:0] mem [256];
  logic [7:0] lastVal = 8'h00;
  logic [2:0] lowCnt = 3'h0;
  always @(posedge clk) begin
    if (!extWrN && extDataOe) mem[extAddr[7:0]] <= extWrData;
    if (extRdN) lowCnt <= 3'h0;
    else if (lowCnt != 3'h7) lowCnt <= lowCnt + 3'h1;
    lastVal <= extRdData;
  end
  // churn instead of a stale byte, so an early capture cannot pass by luck
  always_comb begin
    if (!extRdN && lowCnt >= rdDelay) extRdData = mem[extAddr[7:0]];
    else extRdData = ~lastVal;
  end
endmodule : mcs_ext_mem

// ### mcs_mod_counter.sv
`timescale 1ns/1ps
module mcs_mod_counter #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned MOD   = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // count
  output logic [WIDTH-1:0] count,
  output logic             wrapNext
);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(MOD - 1);

  assign wrapNext = (count == LAST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (wrapNext) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule : mcs_mod_counter

// ### mcs_timing_pkg.sv
package mcs_timing_pkg;
  // clock states of one machine cycle
  typedef enum logic [1:0] {
    STATE_FIRST  = 2'b00,
    STATE_SECOND = 2'b01,
    STATE_THIRD  = 2'b10,
    STATE_FOURTH = 2'b11
  } mcs_state_e;

  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned STATES_PER_CYCLE = 4;
  localparam int unsigned MAX_INSTR_CYCLES = 5;

  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam int unsigned STRETCH_LSB       = 0;
  localparam int unsigned STRETCH_MSB       = 2;

  localparam logic [4:0] STROBE_WIDTH_MIN   = 5'h02;
  localparam logic [4:0] STROBE_LEAD        = 5'h00;
  localparam logic [1:0] RESET_HOLD_CYCLES  = 2'h2;
  localparam logic [15:0] PC_RESET          = 16'h0000;
endpackage : mcs_timing_pkg
